// >>> hdl/tal_alert.sv
// threshold alert unit: limit and mask registers, flags and alert pin
//
// What this block does
// - one limit register at offset 07h
// - five selectable over/under limit functions
// - open-drain alert pin asserts on violation
// - highest enabled bit selects the function
// - ready routing adds conversion done to pin
// - done flag bit 3, limit flag bit 4
// - without ready routing only limit drives pin
// - shunt functions compare after each shunt conversion
// - limit flag sets when measurement passes limit in the selected direction
// - pin active level from bit 1
// - latched: hold until config write or mask read
// - bus functions compare after each bus conversion
// - power compared after each bus conversion
// - compare single results, not averaged ones
// - done flag sets after full cycle completes
// - done flag clears on non-power-down config write or status read
`timescale 1ns/1ps
`default_nettype none
`include "tal_cfg.svh"
module tal_alert
  import tal_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`TAL_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`TAL_DATA_W-1:0] reg_wdata,
  output logic [`TAL_DATA_W-1:0] reg_rdata,
  input wire logic shunt_valid,
  input wire logic [15:0] shunt_value,
  input wire logic bus_valid,
  input wire logic [15:0] bus_value,
  input wire logic [15:0] power_value,
  input wire logic cycle_done,
  output logic alert_out,
  output logic alert_oe
);

  // =====================================================================
  // state
  logic [15:0] threshold_limit;
  logic [15:0] mask_ctrl;
  logic conversion_done_flag;
  logic limit_hit_flag;
  logic [`TAL_DATA_W-1:0] next_reg_rdata;
  logic [15:0] next_threshold_limit;
  logic [15:0] next_mask_ctrl;
  logic next_conversion_done_flag;
  logic next_limit_hit_flag;
  logic next_alert_oe;

  logic wr_config;
  logic wr_mask;
  logic wr_limit;
  logic rd_mask;
  logic cfg_powerdown;
  logic cmp_valid;
  logic cmp_hit;
  logic latch_en;
  logic ready_to_pin_en;
  logic pin_active_level_sel;
  logic pin_asserted;
  logic [15:0] mask_view;
  tal_enables_t enables;
  tal_sample_t sample;

  // =====================================================================
  // decode
  always_comb
  begin
    wr_config = 1'b0;
    wr_mask = 1'b0;
    wr_limit = 1'b0;
    rd_mask = 1'b0;
    if (reg_wr && reg_addr == `TAL_ADDR_CONFIG)
      wr_config = 1'b1;
    else if (reg_wr && reg_addr == `TAL_ADDR_MASK)
      wr_mask = 1'b1;
    else if (reg_wr && reg_addr == `TAL_ADDR_LIMIT)
      wr_limit = 1'b1;
    // the mask register doubles as the status register
    if (reg_rd && reg_addr == `TAL_ADDR_MASK)
      rd_mask = 1'b1;
  end

  // power-down codes leave the done flag alone
  assign cfg_powerdown =
    (reg_wdata[`TAL_MODE_LSB +: 3] & `TAL_MODE_PD_MASK) == 3'h0;

  assign latch_en = mask_ctrl[`TAL_BIT_LATCH];
  assign ready_to_pin_en = mask_ctrl[`TAL_BIT_READY_PIN];
  assign pin_active_level_sel = mask_ctrl[`TAL_BIT_ACTIVE_LEVEL];

  assign enables.shunt_over = mask_ctrl[`TAL_BIT_SHUNT_OVER];
  assign enables.shunt_under = mask_ctrl[`TAL_BIT_SHUNT_UNDER];
  assign enables.bus_over = mask_ctrl[`TAL_BIT_BUS_OVER];
  assign enables.bus_under = mask_ctrl[`TAL_BIT_BUS_UNDER];
  assign enables.power_over = mask_ctrl[`TAL_BIT_POWER_OVER];

  assign sample.shunt_valid = shunt_valid;
  assign sample.bus_valid = bus_valid;
  assign sample.shunt = shunt_value;
  assign sample.bus = bus_value;
  assign sample.power = power_value;

  // =====================================================================
  // comparison
  tal_compare u_compare (
    .enables (enables),
    .limit (threshold_limit),
    .sample (sample),
    .cmp_valid (cmp_valid),
    .cmp_hit (cmp_hit)
  );

  // =====================================================================
  // registers and flags
  always_comb
  begin
    next_threshold_limit = threshold_limit;
    next_mask_ctrl = mask_ctrl;
    next_conversion_done_flag = conversion_done_flag;
    next_limit_hit_flag = limit_hit_flag;
    if (wr_limit)
      next_threshold_limit = reg_wdata;
    if (wr_mask)
      next_mask_ctrl = reg_wdata & `TAL_MASK_WR_BITS;
    // clear first, so a same-cycle set below wins
    if ((wr_config && !cfg_powerdown) || rd_mask)
      next_conversion_done_flag = 1'b0;
    if (cycle_done)
      next_conversion_done_flag = 1'b1;
    if (latch_en)
    begin
      if (wr_config || rd_mask)
        next_limit_hit_flag = 1'b0;
      if (cmp_valid && cmp_hit)
        next_limit_hit_flag = 1'b1;
    end
    else if (cmp_valid)
      next_limit_hit_flag = cmp_hit;
    else if (!(|(mask_ctrl[`TAL_BIT_SHUNT_OVER:`TAL_BIT_POWER_OVER])))
      // no function selected: nothing can keep the flag up
      next_limit_hit_flag = 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      threshold_limit <= `TAL_LIMIT_RESET;
      mask_ctrl <= `TAL_MASK_RESET;
      conversion_done_flag <= 1'b0;
      limit_hit_flag <= 1'b0;
    end
    else
    begin
      threshold_limit <= next_threshold_limit;
      mask_ctrl <= next_mask_ctrl;
      conversion_done_flag <= next_conversion_done_flag;
      limit_hit_flag <= next_limit_hit_flag;
    end
  end

  // =====================================================================
  // read data, registered one cycle after the read strobe
  always_comb
  begin
    mask_view = mask_ctrl;
    mask_view[`TAL_BIT_CONV_DONE] = conversion_done_flag;
    mask_view[`TAL_BIT_LIMIT_HIT] = limit_hit_flag;
    next_reg_rdata = reg_rdata;
    if (reg_rd)
    begin
      if (reg_addr == `TAL_ADDR_MASK)
        next_reg_rdata = mask_view;
      else if (reg_addr == `TAL_ADDR_LIMIT)
        next_reg_rdata = threshold_limit;
      else
        next_reg_rdata = 16'h0000;
    end
  end

  // =====================================================================
  // alert pin: open drain, only ever pulls low
  always_comb
  begin
    // the pin follows the flags of the next cycle, so a hit and
    // its pin change appear together
    pin_asserted = next_limit_hit_flag;
    if (ready_to_pin_en && next_conversion_done_flag)
      pin_asserted = 1'b1;
    // active low pulls while asserted, active high while idle
    if (pin_active_level_sel)
      next_alert_oe = !pin_asserted;
    else
      next_alert_oe = pin_asserted;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 16'h0000;
      alert_out <= 1'b0;
      alert_oe <= 1'b0;
    end
    else
    begin
      reg_rdata <= next_reg_rdata;
      alert_out <= 1'b0;
      alert_oe <= next_alert_oe;
    end
  end

endmodule
`default_nettype wire

// >>> hdl/tal_cfg.svh
// register offsets, field positions and reset values of the alert unit
`ifndef TAL_CFG_SVH
`define TAL_CFG_SVH

`define TAL_ADDR_W 8
`define TAL_DATA_W 16

`define TAL_ADDR_CONFIG 8'h00
`define TAL_ADDR_MASK 8'h06
`define TAL_ADDR_LIMIT 8'h07

`define TAL_BIT_SHUNT_OVER 15
`define TAL_BIT_SHUNT_UNDER 14
`define TAL_BIT_BUS_OVER 13
`define TAL_BIT_BUS_UNDER 12
`define TAL_BIT_POWER_OVER 11
`define TAL_BIT_READY_PIN 10
`define TAL_BIT_LIMIT_HIT 4
`define TAL_BIT_CONV_DONE 3
`define TAL_BIT_ACTIVE_LEVEL 1
`define TAL_BIT_LATCH 0

`define TAL_MASK_WR_BITS 16'hFC03
`define TAL_MASK_RESET 16'h0000
`define TAL_LIMIT_RESET 16'h0000

`define TAL_MODE_LSB 0
`define TAL_MODE_PD_MASK 3'h3

`endif

// >>> hdl/tal_compare.sv
// function selection and limit comparison of one result
`timescale 1ns/1ps
`default_nettype none
module tal_compare
  import tal_pkg::*;
(
  input wire tal_enables_t enables,
  input wire logic [15:0] limit,
  input wire tal_sample_t sample,
  output logic cmp_valid,
  output logic cmp_hit
);

  tal_func_t func;

  // =====================================================================
  // selection: highest enable bit wins
  always_comb
  begin
    if (enables.shunt_over)
      func = TAL_FN_SHUNT_OVER;
    else if (enables.shunt_under)
      func = TAL_FN_SHUNT_UNDER;
    else if (enables.bus_over)
      func = TAL_FN_BUS_OVER;
    else if (enables.bus_under)
      func = TAL_FN_BUS_UNDER;
    else if (enables.power_over)
      func = TAL_FN_POWER_OVER;
    else
      func = TAL_FN_NONE;
  end

  // =====================================================================
  // comparison per single conversion, never on averaged data
  always_comb
  begin
    cmp_valid = 1'b0;
    cmp_hit = 1'b0;
    case (func)
      TAL_FN_SHUNT_OVER:
      begin
        cmp_valid = sample.shunt_valid;
        cmp_hit = $signed(sample.shunt) > $signed(limit);
      end
      TAL_FN_SHUNT_UNDER:
      begin
        cmp_valid = sample.shunt_valid;
        cmp_hit = $signed(sample.shunt) < $signed(limit);
      end
      TAL_FN_BUS_OVER:
      begin
        cmp_valid = sample.bus_valid;
        cmp_hit = sample.bus > limit;
      end
      TAL_FN_BUS_UNDER:
      begin
        cmp_valid = sample.bus_valid;
        cmp_hit = sample.bus < limit;
      end
      TAL_FN_POWER_OVER:
      begin
        // power is ready alongside each bus conversion
        cmp_valid = sample.bus_valid;
        cmp_hit = sample.power > limit;
      end
      default:
      begin
        cmp_valid = 1'b0;
        cmp_hit = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire

// >>> hdl/tal_pkg.sv
// types shared by the alert unit modules
`default_nettype none
package tal_pkg;

  typedef struct packed {
    logic shunt_valid;
    logic bus_valid;
    logic [15:0] shunt;
    logic [15:0] bus;
    logic [15:0] power;
  } tal_sample_t;

  typedef struct packed {
    logic shunt_over;
    logic shunt_under;
    logic bus_over;
    logic bus_under;
    logic power_over;
  } tal_enables_t;

  typedef enum logic [2:0] {
    TAL_FN_NONE,
    TAL_FN_SHUNT_OVER,
    TAL_FN_SHUNT_UNDER,
    TAL_FN_BUS_OVER,
    TAL_FN_BUS_UNDER,
    TAL_FN_POWER_OVER
  } tal_func_t;

endpackage
`default_nettype wire

// >>> tb/tal_alert_assertions.sv
// concurrent checks on the alert unit ports
`timescale 1ns/1ps
`default_nettype none
`include "tal_cfg.svh"
module tal_alert_assertions
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`TAL_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`TAL_DATA_W-1:0] reg_wdata,
  input wire logic [`TAL_DATA_W-1:0] reg_rdata,
  input wire logic shunt_valid,
  input wire logic [15:0] shunt_value,
  input wire logic bus_valid,
  input wire logic [15:0] bus_value,
  input wire logic [15:0] power_value,
  input wire logic cycle_done,
  input wire logic alert_out,
  input wire logic alert_oe
);
  // ==========
  // shadow copies of the writable registers
  logic [15:0] m;
  logic [15:0] lim;
  logic [15:0] next_m;
  logic [15:0] next_lim;
  logic q;
  assign q = !reg_wr && !reg_rd;
  always_comb
  begin
    next_m = m;
    next_lim = lim;
    if (reg_wr && reg_addr == `TAL_ADDR_MASK)
      next_m = reg_wdata & `TAL_MASK_WR_BITS;
    if (reg_wr && reg_addr == `TAL_ADDR_LIMIT)
      next_lim = reg_wdata;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      m <= 16'h0000;
      lim <= 16'h0000;
    end
    else
    begin
      m <= next_m;
      lim <= next_lim;
    end
  end
  // ==========
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_data_low: assert property (alert_out == 1'b0)
    else $error("alert data driven high");
  a_shunt_over: assert property (shunt_valid && q && m[15] && !m[1]
    && $signed(shunt_value) > $signed(lim) |=> alert_oe)
    else $error("shunt over limit not signalled");
  a_bus_under: assert property (bus_valid && q && m[15:12] == 4'h1
    && !m[1] && bus_value < lim |=> alert_oe)
    else $error("bus under limit not signalled");
  a_power_over: assert property (bus_valid && q && m[15:11] == 5'h01
    && !m[1] && power_value > lim |=> alert_oe)
    else $error("power over limit not signalled");
  a_ready_pin: assert property (cycle_done && q && m[10] && !m[1]
    |=> alert_oe) else $error("ready not routed to pin");
  // pin must stem from the current mask, not one written a cycle ago
  a_latch_hold: assert property (alert_oe && q && m[0] && !m[1]
    && !m[10] && $stable(m) |=> alert_oe)
    else $error("latched alert dropped");
  a_idle_level: assert property ((q && m[15:10] == 6'h00 && !m[0])[*3]
    |-> alert_oe == m[1]) else $error("idle pin level wrong");
  a_limit_read: assert property (reg_rd && !reg_wr
    && reg_addr == `TAL_ADDR_LIMIT |=> reg_rdata == lim)
    else $error("limit readback wrong");
  c_shunt: cover property (shunt_valid && m[15]);
  c_ready: cover property (cycle_done && m[10]);
  c_latch: cover property (alert_oe && m[0]);
endmodule
bind tal_alert tal_alert_assertions i_chk (.clk, .rst_n, .reg_addr,
  .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .shunt_valid, .shunt_value,
  .bus_valid, .bus_value, .power_value, .cycle_done, .alert_out,
  .alert_oe);
`default_nettype wire

// >>> tb/tal_alert_bench.sv
// self-checking bench of the alert unit
`timescale 1ns/1ps
`default_nettype none
`include "tal_cfg.svh"
module tal_alert_bench import tal_pkg::*;;
  logic clk = 1'b0;
  logic rst_n, reg_wr, reg_rd, shunt_valid, bus_valid, cycle_done;
  logic alert_out, alert_oe, pin;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, shunt_value, bus_value;
  int bad_count, checks_done;
  always #10 clk = ~clk;
  // power result follows the bus value so one figure serves both
  tal_alert i_dut (.clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .shunt_valid, .shunt_value, .bus_valid, .bus_value,
    .power_value(bus_value), .cycle_done, .alert_out, .alert_oe);
  tal_host_model i_host (.alert_out, .alert_oe, .pin_level(pin));
  // ==========
  // shared tasks
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk("reg_rdata", e, reg_rdata);
  endtask
  task meas(input logic s, input logic b, input logic d,
    input logic [15:0] v);
    @(negedge clk);
    {shunt_valid, bus_valid, cycle_done} = {s, b, d};
    shunt_value = v;
    bus_value = v;
    @(negedge clk);
    {shunt_valid, bus_valid, cycle_done} = 3'h0;
  endtask
  // an extra cycle lets a register write reach the pin first
  task pin_is(input logic e);
    @(negedge clk);
    chk("alert pin", {15'h0000, e}, {15'h0000, pin});
  endtask
  task stop_test;
    if (bad_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========
  // scenarios
  task t_reset;
    rd(`TAL_ADDR_MASK, 16'h0000);
    rd(`TAL_ADDR_LIMIT, 16'h0000);
    rd(8'h05, 16'h0000);
    pin_is(1'b1);
  endtask
  task t_shunt;
    wr(`TAL_ADDR_LIMIT, 16'h0100);
    rd(`TAL_ADDR_LIMIT, 16'h0100);
    wr(`TAL_ADDR_MASK, 16'h8000);
    meas(1'b1, 1'b0, 1'b0, 16'h0200);
    pin_is(1'b0);
    rd(`TAL_ADDR_MASK, 16'h8010);
    meas(1'b1, 1'b0, 1'b0, 16'h0050);
    pin_is(1'b1);
    meas(1'b1, 1'b0, 1'b0, 16'hFF00);
    meas(1'b0, 1'b1, 1'b0, 16'h0200);
    pin_is(1'b1);
  endtask
  task t_select;
    wr(`TAL_ADDR_MASK, 16'hC000);
    meas(1'b1, 1'b0, 1'b0, 16'h0050);
    pin_is(1'b1);
    wr(`TAL_ADDR_MASK, 16'h4000);
    meas(1'b1, 1'b0, 1'b0, 16'hFFF0);
    pin_is(1'b0);
    wr(`TAL_ADDR_MASK, 16'h2000);
    meas(1'b0, 1'b1, 1'b0, 16'h0200);
    pin_is(1'b0);
    wr(`TAL_ADDR_MASK, 16'h1800);
    meas(1'b0, 1'b1, 1'b0, 16'h0200);
    pin_is(1'b1);
    wr(`TAL_ADDR_MASK, 16'h0800);
    meas(1'b0, 1'b1, 1'b0, 16'h0200);
    pin_is(1'b0);
    meas(1'b0, 1'b1, 1'b0, 16'h0100);
    pin_is(1'b1);
    wr(`TAL_ADDR_MASK, 16'h1000);
    meas(1'b0, 1'b1, 1'b0, 16'h0050);
    pin_is(1'b0);
  endtask
  task t_latch;
    wr(`TAL_ADDR_MASK, 16'h8001);
    meas(1'b1, 1'b0, 1'b0, 16'h0200);
    meas(1'b1, 1'b0, 1'b0, 16'h0050);
    pin_is(1'b0);
    rd(`TAL_ADDR_MASK, 16'h8011);
    pin_is(1'b1);
    meas(1'b1, 1'b0, 1'b0, 16'h0200);
    wr(`TAL_ADDR_CONFIG, 16'h0007);
    pin_is(1'b1);
  endtask
  task t_ready;
    wr(`TAL_ADDR_MASK, 16'h0400);
    meas(1'b0, 1'b0, 1'b1, 16'h0000);
    pin_is(1'b0);
    wr(`TAL_ADDR_CONFIG, 16'h0000);
    rd(`TAL_ADDR_MASK, 16'h0408);
    pin_is(1'b1);
    meas(1'b0, 1'b0, 1'b1, 16'h0000);
    wr(`TAL_ADDR_CONFIG, 16'h0007);
    rd(`TAL_ADDR_MASK, 16'h0400);
    wr(`TAL_ADDR_MASK, 16'h0000);
    meas(1'b0, 1'b0, 1'b1, 16'h0000);
    pin_is(1'b1);
  endtask
  task t_polarity;
    wr(`TAL_ADDR_MASK, 16'h0002);
    pin_is(1'b0);
    wr(`TAL_ADDR_MASK, 16'h8002);
    meas(1'b1, 1'b0, 1'b0, 16'h0200);
    pin_is(1'b1);
  endtask
  // reset in mid-run must drop flags, registers and the pulled pin
  task t_midreset;
    wr(`TAL_ADDR_MASK, 16'h0002);
    pin_is(1'b0);
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rd(`TAL_ADDR_MASK, 16'h0000);
    rd(`TAL_ADDR_LIMIT, 16'h0000);
    pin_is(1'b1);
  endtask
  // ==========
  // main sequence and guard against a hang
  initial
  begin
    {rst_n, reg_wr, reg_rd, shunt_valid, bus_valid, cycle_done} = 6'h00;
    {reg_addr, reg_wdata, shunt_value, bus_value} = 56'h0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_shunt();
    t_select();
    t_latch();
    t_ready();
    t_polarity();
    t_midreset();
    stop_test();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    stop_test();
  end
endmodule
`default_nettype wire

// >>> tb/tal_host_model.sv
// host side of the alert wire: pull-up and interrupt input level
`timescale 1ns/1ps
`default_nettype none
module tal_host_model
(
  input wire logic alert_out,
  input wire logic alert_oe,
  output logic pin_level
);
  // ==========
  // wire level
  // released wire floats up through the pull-up
  assign pin_level = alert_oe ? alert_out : 1'b1;
endmodule
`default_nettype wire
